// [lte_exec.sv]
// lte_exec: execution timing and datapath for test, xor, zero-extend,
// memory bit probe, plus cycle counts of the loads and frame preparation
// assumes: operand values are read by the core and arrive with the issue;
// the operand memory answers with mem_ready, low for each wait state
//
// Notes on behaviour
// RULE_01: and-test ANDs two registers, writes none, ov=0, s/z set, one clock.
// RULE_02: displacement probe: base plus signed 16-bit offset, z = not bit#3.
// RULE_03: register probe: base register is the address, bit from second reg.
// RULE_04: probe takes three clocks, plus one per read wait state.
// RULE_05: register xor writes dst^src into dst, ov=0, s/z set, one clock.
// RULE_06: immediate xor: src ^ zero-extended imm16 into other dst, one clock.
// RULE_07: byte zero-extend in place, no flags, one clock.
// RULE_08: halfword zero-extend in place, no flags, one clock.
// RULE_09: disp9 upper eight bits come from the opcode field.
// RULE_10: marked instruction takes three clocks after a status word rewrite.
// RULE_11: list load with empty list times like a one-register list.
// RULE_12: marked register field of all zeros is an illegal form.
// RULE_13: long branch offset upper 21 bits come from the opcode.
// RULE_14: short loads take one clock plus wait states.
// RULE_15: marked accesses take two clocks plus wait states.
// RULE_16: system register load: source from first field, index from second.
// RULE_17: nine-bit constant built from low five and high four bit fields.
// RULE_18: software never names the same register as first and third operand.
// RULE_19: frame preparation picks its pointer source by sub-opcode bits.
// RULE_20: code 00 sp, 01 sext imm16, 10 imm16<<16, 11 imm32.
// RULE_21: frame preparation with imm32 takes register count plus three.
`timescale 1ns/100ps
`default_nettype none
`include "lte_regs.svh"

module lte_exec (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // instruction issue
    input wire logic issue_valid,
    input wire lte_pkg::lte_issue_t issue,
    output logic issue_ready,
    input wire logic stat_ext_write,
    // operand memory
    output logic mem_req,
    output logic [31:0] mem_addr,
    input wire logic mem_ready,
    input wire logic [7:0] mem_rdata,
    // retire
    output logic done,
    output logic illegal,
    output logic wr_en,
    output logic [4:0] wr_idx,
    output logic [31:0] wr_data,
    output var lte_pkg::lte_flags_t flags,
    output logic ep_we,
    output logic [31:0] ep_data,
    output var lte_pkg::lte_fields_t fields_q
);
    lte_pkg::lte_fields_t fields_c;

    lte_field_decode u_fields (
        .issue(issue),
        .fields(fields_c)
    );

    function automatic logic [3:0] list_count(input logic [11:0] l);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < 12; i++) begin
            n = n + {3'h0, l[i]};
        end
        return n;
    endfunction

    // sequencer state
    lte_pkg::lte_state_t state_ff, nxt_state;
    lte_pkg::lte_class_t cls_ff, nxt_cls;
    logic [3:0] rem_ff, nxt_rem;
    logic [31:0] addr_ff, nxt_addr;
    logic [2:0] bit_ff, nxt_bit;
    logic zbit_ff, nxt_zbit;
    logic stat_dirty_ff, nxt_stat_dirty;
    // held results for stretched instructions
    logic [31:0] res_ff, nxt_res;
    logic [4:0] idx_ff, nxt_idx;
    logic we_ff, nxt_we;
    lte_pkg::lte_flags_t fl_ff, nxt_fl;
    logic epw_ff, nxt_epw;
    logic [31:0] ep_ff, nxt_ep;
    // published outputs
    logic done_ff, nxt_done;
    logic illegal_ff, nxt_illegal;
    logic wr_en_ff, nxt_wr_en;
    logic [4:0] wr_idx_ff, nxt_wr_idx;
    logic [31:0] wr_data_ff, nxt_wr_data;
    lte_pkg::lte_flags_t flags_ff, nxt_flags;
    logic ep_we_ff, nxt_ep_we;
    logic [31:0] ep_data_ff, nxt_ep_data;
    lte_pkg::lte_fields_t fields_ff, nxt_fields;

    // issue-side combinational results
    logic [31:0] res_c, t_c;
    logic [4:0] idx_c;
    logic we_c;
    lte_pkg::lte_flags_t fl_c;
    logic [31:0] addr_c;
    logic [2:0] bit_c;
    logic [3:0] total_c, n_c;
    logic writes_flags_c;

    always_comb begin
        res_c = 32'h0;
        t_c = 32'h0;
        idx_c = 5'h00;
        we_c = 1'b0;
        fl_c = '0;
        addr_c = 32'h0;
        bit_c = 3'h0;
        n_c = list_count(issue.register_select_list);
        total_c = `LTE_CLK_SINGLE;
        unique case (issue.cls)
            lte_pkg::lte_cls_and_test_no_write: begin
                t_c = issue.ra_val & issue.rb_val; // RULE_01
                fl_c = '{ov_we: 1'b1, s_we: 1'b1, z_we: 1'b1, ov: 1'b0,
                    s: t_c[31], z: (t_c == 32'h0)};
            end
            lte_pkg::lte_cls_xor_register: begin
                res_c = issue.ra_val ^ issue.rb_val; // RULE_05
                idx_c = issue.hw0[`LTE_F_RA_HI:`LTE_F_RA_LO];
                we_c = 1'b1;
                fl_c = '{ov_we: 1'b1, s_we: 1'b1, z_we: 1'b1, ov: 1'b0,
                    s: res_c[31], z: (res_c == 32'h0)};
            end
            lte_pkg::lte_cls_exclusive_or_immediate: begin
                res_c = issue.rb_val ^ {16'h0000, issue.hw1}; // RULE_06
                idx_c = issue.hw0[`LTE_F_RA_HI:`LTE_F_RA_LO];
                we_c = 1'b1;
                fl_c = '{ov_we: 1'b1, s_we: 1'b1, z_we: 1'b1, ov: 1'b0,
                    s: res_c[31], z: (res_c == 32'h0)};
            end
            lte_pkg::lte_cls_zero_extend_byte: begin
                res_c = {24'h00_0000, issue.rb_val[7:0]}; // RULE_07
                idx_c = issue.hw0[`LTE_F_RB_HI:`LTE_F_RB_LO];
                we_c = 1'b1;
            end
            lte_pkg::lte_cls_zero_extend_halfword: begin
                res_c = {16'h0000, issue.rb_val[15:0]}; // RULE_08
                idx_c = issue.hw0[`LTE_F_RB_HI:`LTE_F_RB_LO];
                we_c = 1'b1;
            end
            lte_pkg::lte_cls_probe_disp: begin
                addr_c = issue.rb_val + {{16{issue.hw1[15]}}, issue.hw1}; // RULE_02
                bit_c = issue.hw0[`LTE_F_BIT_HI:`LTE_F_BIT_LO];
                total_c = `LTE_CLK_PROBE; // RULE_04
            end
            lte_pkg::lte_cls_probe_reg: begin
                addr_c = issue.rb_val; // RULE_03
                bit_c = issue.ra_val[2:0];
                total_c = `LTE_CLK_PROBE;
            end
            lte_pkg::lte_cls_marked_access: total_c = `LTE_CLK_MARKED; // RULE_15
            lte_pkg::lte_cls_list_load: begin
                total_c = (n_c == 4'h0) ? 4'h1 : n_c; // RULE_11
            end
            lte_pkg::lte_cls_frame_prep: begin
                if (fields_c.ep_src == `LTE_EP_IMM32) begin
                    total_c = n_c + `LTE_CLK_FRAME_IMM32; // RULE_21
                end else if (fields_c.ep_src == `LTE_EP_SP) begin
                    total_c = n_c + `LTE_CLK_FRAME_SP;
                end else begin
                    total_c = n_c + `LTE_CLK_FRAME_IMM16;
                end
            end
            default: total_c = `LTE_CLK_SINGLE; // RULE_14
        endcase
        // a status word rewrite just before stretches a marked instruction
        if (issue.cond_dep && stat_dirty_ff) begin
            total_c = `LTE_CLK_STAT_DEP; // RULE_10
        end
        writes_flags_c = fl_c.z_we;
    end

    // access, stall and retire decisions
    logic idle, active, take, acc, stall, finish, bad;
    lte_pkg::lte_class_t cur_cls;
    logic [3:0] cur_rem;

    always_comb begin
        idle = (state_ff == lte_pkg::lte_st_idle);
        bad = fields_c.reg_field_bad;
        take = idle && issue_valid;
        active = idle ? (issue_valid && !bad) : 1'b1;
        cur_cls = idle ? issue.cls : cls_ff;
        cur_rem = idle ? total_c : rem_ff;
        // which clock of an instruction holds its memory read
        unique case (cur_cls)
            lte_pkg::lte_cls_probe_disp,
            lte_pkg::lte_cls_probe_reg: acc = (cur_rem == `LTE_PROBE_ACC_REM);
            lte_pkg::lte_cls_short_load,
            lte_pkg::lte_cls_marked_access: acc = (cur_rem == 4'h1);
            lte_pkg::lte_cls_list_load: acc = 1'b1;
            default: acc = 1'b0;
        endcase
        acc = acc && active;
        stall = acc && !mem_ready; // RULE_04
        finish = active && !stall && (cur_rem == 4'h1);
    end

    assign issue_ready = idle;
    assign mem_req = acc;
    assign mem_addr = addr_ff;

    always_comb begin
        nxt_state = state_ff;
        nxt_cls = cls_ff;
        nxt_rem = rem_ff;
        nxt_addr = addr_ff;
        nxt_bit = bit_ff;
        nxt_zbit = zbit_ff;
        nxt_res = res_ff;
        nxt_idx = idx_ff;
        nxt_we = we_ff;
        nxt_fl = fl_ff;
        nxt_epw = epw_ff;
        nxt_ep = ep_ff;
        nxt_done = 1'b0;
        nxt_illegal = take && bad; // RULE_12
        nxt_wr_en = 1'b0;
        nxt_wr_idx = wr_idx_ff;
        nxt_wr_data = wr_data_ff;
        nxt_flags = '0;
        nxt_ep_we = 1'b0;
        nxt_ep_data = ep_data_ff;
        nxt_fields = take ? fields_c : fields_ff;
        nxt_stat_dirty = stat_dirty_ff;
        if (take && !bad) begin
            nxt_cls = issue.cls;
            nxt_addr = addr_c;
            nxt_bit = bit_c;
            nxt_res = res_c;
            nxt_idx = idx_c;
            nxt_we = we_c;
            nxt_fl = fl_c;
            nxt_epw = (issue.cls == lte_pkg::lte_cls_frame_prep);
            nxt_ep = fields_c.element_pointer;
            nxt_stat_dirty = 1'b0;
        end
        if (acc && mem_ready) begin
            nxt_zbit = mem_rdata[idle ? bit_c : bit_ff];
        end
        if (finish) begin
            nxt_state = lte_pkg::lte_st_idle;
            nxt_done = 1'b1;
            if (idle) begin
                nxt_wr_en = we_c;
                nxt_wr_idx = idx_c;
                nxt_wr_data = res_c;
                nxt_flags = fl_c;
                nxt_ep_we = (issue.cls == lte_pkg::lte_cls_frame_prep);
                nxt_ep_data = fields_c.element_pointer;
                nxt_stat_dirty = writes_flags_c;
            end else if (cls_ff == lte_pkg::lte_cls_probe_disp ||
                cls_ff == lte_pkg::lte_cls_probe_reg) begin
                // only the zero flag moves; memory is left untouched
                nxt_flags.z_we = 1'b1; // RULE_02 RULE_03
                nxt_flags.z = ~zbit_ff;
                nxt_stat_dirty = 1'b1;
            end else begin
                nxt_wr_en = we_ff;
                nxt_wr_idx = idx_ff;
                nxt_wr_data = res_ff;
                nxt_flags = fl_ff;
                nxt_ep_we = epw_ff;
                nxt_ep_data = ep_ff;
                nxt_stat_dirty = fl_ff.z_we;
            end
        end else if (active) begin
            nxt_state = lte_pkg::lte_st_run;
            nxt_rem = stall ? cur_rem : cur_rem - 4'h1;
        end
        if (stat_ext_write) begin
            nxt_stat_dirty = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff <= lte_pkg::lte_st_idle;
            cls_ff <= lte_pkg::lte_cls_none;
            rem_ff <= `LTE_RST_REM;
            addr_ff <= `LTE_RST_WORD;
            bit_ff <= 3'h0;
            zbit_ff <= 1'b0;
            stat_dirty_ff <= 1'b0;
            res_ff <= `LTE_RST_WORD;
            idx_ff <= 5'h00;
            we_ff <= 1'b0;
            fl_ff <= '0;
            epw_ff <= 1'b0;
            ep_ff <= `LTE_RST_WORD;
            done_ff <= 1'b0;
            illegal_ff <= 1'b0;
            wr_en_ff <= 1'b0;
            wr_idx_ff <= 5'h00;
            wr_data_ff <= `LTE_RST_WORD;
            flags_ff <= '0;
            ep_we_ff <= 1'b0;
            ep_data_ff <= `LTE_RST_WORD;
            fields_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            cls_ff <= nxt_cls;
            rem_ff <= nxt_rem;
            addr_ff <= nxt_addr;
            bit_ff <= nxt_bit;
            zbit_ff <= nxt_zbit;
            stat_dirty_ff <= nxt_stat_dirty;
            res_ff <= nxt_res;
            idx_ff <= nxt_idx;
            we_ff <= nxt_we;
            fl_ff <= nxt_fl;
            epw_ff <= nxt_epw;
            ep_ff <= nxt_ep;
            done_ff <= nxt_done;
            illegal_ff <= nxt_illegal;
            wr_en_ff <= nxt_wr_en;
            wr_idx_ff <= nxt_wr_idx;
            wr_data_ff <= nxt_wr_data;
            flags_ff <= nxt_flags;
            ep_we_ff <= nxt_ep_we;
            ep_data_ff <= nxt_ep_data;
            fields_ff <= nxt_fields;
        end
    end

    assign done = done_ff;
    assign illegal = illegal_ff;
    assign wr_en = wr_en_ff;
    assign wr_idx = wr_idx_ff;
    assign wr_data = wr_data_ff;
    assign flags = flags_ff;
    assign ep_we = ep_we_ff;
    assign ep_data = ep_data_ff;
    assign fields_q = fields_ff;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    logic plain_take;
    assign plain_take = take && !bad && !(issue.cond_dep && stat_dirty_ff);

    sequence s_probe_take;
        plain_take && (issue.cls == lte_pkg::lte_cls_probe_disp ||
            issue.cls == lte_pkg::lte_cls_probe_reg);
    endsequence
    sequence s_probe_read;
        ##1 (mem_req && mem_ready);
    endsequence

    a_and_test_quiet: assert property (plain_take && // RULE_01
        issue.cls == lte_pkg::lte_cls_and_test_no_write |=> done && !wr_en &&
        flags.ov_we && !flags.ov && flags.z == ($past(issue.ra_val & issue.rb_val) == 32'h0))
        else $error("and-test wrote a register or set flags wrong");
    a_probe_three_clk: assert property (s_probe_take ##0 s_probe_read // RULE_04
        |-> ##1 !done ##1 done)
        else $error("bit probe did not take three clocks");
    a_probe_wait_hold: assert property (mem_req && !mem_ready |=> mem_req && !done) // RULE_04
        else $error("wait state did not hold the read");
    // list loads also read at this count, so only probes qualify
    a_probe_zero_inv: assert property (mem_req && mem_ready && !idle && // RULE_03
        (cls_ff == lte_pkg::lte_cls_probe_disp || cls_ff == lte_pkg::lte_cls_probe_reg) &&
        rem_ff == `LTE_PROBE_ACC_REM |-> ##2 (flags.z_we && !flags.s_we &&
        flags.z == !$past(mem_rdata[bit_ff], 2)))
        else $error("probe zero flag is not the inverted bit");
    a_xor_reg_result: assert property (plain_take && // RULE_05
        issue.cls == lte_pkg::lte_cls_xor_register |=> wr_en &&
        wr_data == $past(issue.ra_val ^ issue.rb_val) && !flags.ov)
        else $error("register xor result wrong");
    a_xor_imm_ext: assert property (plain_take && // RULE_06
        issue.cls == lte_pkg::lte_cls_exclusive_or_immediate |=>
        wr_data[31:16] == $past(issue.rb_val[31:16]) && flags.s_we)
        else $error("immediate xor did not zero-extend");
    a_byte_ext_top: assert property (plain_take && // RULE_07
        issue.cls == lte_pkg::lte_cls_zero_extend_byte |=> wr_en &&
        wr_data[31:8] == 24'h00_0000 && flags == '0)
        else $error("byte zero-extend wrong");
    a_half_ext_top: assert property (plain_take && // RULE_08
        issue.cls == lte_pkg::lte_cls_zero_extend_halfword |=> wr_en &&
        wr_data[31:16] == 16'h0000 && flags == '0)
        else $error("halfword zero-extend wrong");
    a_stat_dep_stretch: assert property (take && !bad && issue.cond_dep && // RULE_10
        stat_dirty_ff |=> !done ##1 !done ##1 done)
        else $error("marked instruction not stretched to three clocks");
    a_list_empty_one: assert property (plain_take && mem_ready && // RULE_11
        issue.cls == lte_pkg::lte_cls_list_load && issue.register_select_list == 12'h000
        |=> done)
        else $error("empty list did not time as one register");
endmodule
`default_nettype wire

// [lte_field_decode.sv]
// lte_field_decode: pure field assembly from the instruction halfwords
// assumes: halfwords and operand values arrive together in one issue word
`timescale 1ns/100ps
`default_nettype none
`include "lte_regs.svh"

module lte_field_decode (
    // instruction in
    input wire lte_pkg::lte_issue_t issue,
    // decoded fields out
    output var lte_pkg::lte_fields_t fields
);
    logic [4:0] ra_fld;
    logic [4:0] rb_fld;
    logic [1:0] ff;

    always_comb begin
        ra_fld = issue.hw0[`LTE_F_RA_HI:`LTE_F_RA_LO];
        rb_fld = issue.hw0[`LTE_F_RB_HI:`LTE_F_RB_LO];
        ff = issue.hw1[`LTE_F_FF_HI:`LTE_F_FF_LO];
        // upper eight bits from the opcode, bit 0 implied zero
        fields.disp9 = {ra_fld, issue.hw0[`LTE_F_D9_LO_HI:`LTE_F_D9_LO_LO], 1'b0}; // RULE_09
        // upper 21 bits from the opcode, bit 0 implied zero
        fields.long_branch_offset = {issue.hw0[`LTE_F_D22_HI:0], issue.hw1[15:1],
            1'b0}; // RULE_13
        fields.nine_bit_constant = {issue.hw1[`LTE_F_NINE_HI_HI:`LTE_F_NINE_HI_LO],
            rb_fld}; // RULE_17
        // index rides in the field that usually names the second operand
        fields.system_register_index = ra_fld; // RULE_16
        fields.sysreg_src = rb_fld; // RULE_16
        fields.ep_src = ff; // RULE_19
        unique case (ff)
            `LTE_EP_SP: fields.element_pointer = issue.stack_pointer; // RULE_20
            `LTE_EP_SEXT16: fields.element_pointer = {{16{issue.hw2[15]}}, issue.hw2};
            `LTE_EP_SHL16: fields.element_pointer = {issue.hw2, 16'h0000};
            `LTE_EP_IMM32: fields.element_pointer = {issue.hw3, issue.hw2};
        endcase
        fields.reg_field_bad = (issue.chk_ra && ra_fld == 5'h00) ||
            (issue.chk_rb && rb_fld == 5'h00); // RULE_12
    end
endmodule
`default_nettype wire

// [lte_mem_model.sv]
// lte_mem_model: operand memory answering byte reads of the execution block
// assumes: one read at a time, wait-state count set by the bench
`timescale 1ns/100ps
`default_nettype none
module lte_mem_model (
    // clock
    input wire logic clk,
    // read bus
    input wire logic mem_req,
    input wire logic [31:0] mem_addr,
    output logic mem_ready,
    output logic [7:0] mem_rdata,
    // control
    input wire logic [3:0] waits
);
    logic [3:0] wcnt_ff = 4'h0;
    logic [7:0] last_ff = 8'h00;
    always_ff @(posedge clk) begin
        wcnt_ff <= (mem_req && !mem_ready) ? wcnt_ff + 4'h1 : 4'h0;
        if (mem_req && mem_ready) begin
            last_ff <= mem_rdata;
        end
    end
    // held low for each wait state of the read
    assign mem_ready = mem_req && (wcnt_ff == waits);
    // off the bus the data is scrambled so a late sample cannot pass
    assign mem_rdata = (mem_req && mem_ready) ? (mem_addr[7:0] ^ 8'ha5) : ~last_ff;
endmodule
`default_nettype wire

// [lte_pkg.sv]
// lte_pkg: types shared by the execution block and its field decoder
// assumes: compiled before any module that names it
package lte_pkg;

    typedef enum logic [3:0] {
        lte_cls_none                   = 4'h0,
        lte_cls_and_test_no_write      = 4'h1,
        lte_cls_xor_register           = 4'h2,
        lte_cls_exclusive_or_immediate = 4'h3,
        lte_cls_zero_extend_byte       = 4'h4,
        lte_cls_zero_extend_halfword   = 4'h5,
        lte_cls_probe_disp             = 4'h6,
        lte_cls_probe_reg              = 4'h7,
        lte_cls_short_load             = 4'h8,
        lte_cls_marked_access          = 4'h9,
        lte_cls_list_load              = 4'ha,
        lte_cls_frame_prep             = 4'hb,
        lte_cls_sysreg_load            = 4'hc
    } lte_class_t;

    typedef enum logic {
        lte_st_idle = 1'b0,
        lte_st_run  = 1'b1
    } lte_state_t;

    typedef struct packed {
        lte_class_t cls;
        logic cond_dep;
        logic chk_ra;
        logic chk_rb;
        logic [11:0] register_select_list;
        logic [15:0] hw0;
        logic [15:0] hw1;
        logic [15:0] hw2;
        logic [15:0] hw3;
        logic [31:0] ra_val;
        logic [31:0] rb_val;
        logic [31:0] stack_pointer;
    } lte_issue_t;

    typedef struct packed {
        logic ov_we;
        logic s_we;
        logic z_we;
        logic ov;
        logic s;
        logic z;
    } lte_flags_t;

    typedef struct packed {
        logic [8:0] disp9;
        logic [21:0] long_branch_offset;
        logic [8:0] nine_bit_constant;
        logic [4:0] system_register_index;
        logic [4:0] sysreg_src;
        logic [1:0] ep_src;
        logic [31:0] element_pointer;
        logic reg_field_bad;
    } lte_fields_t;

endpackage

// [lte_regs.svh]
// lte_regs.svh: constants for the logic/test/extend execution block
// assumes: included by bare name, definitions only
`ifndef LTE_REGS_SVH
`define LTE_REGS_SVH

// clock counts with no wait states
`define LTE_CLK_SINGLE 4'h1
`define LTE_CLK_MARKED 4'h2
`define LTE_CLK_PROBE 4'h3
`define LTE_CLK_STAT_DEP 4'h3
`define LTE_CLK_FRAME_SP 4'h1
`define LTE_CLK_FRAME_IMM16 4'h2
`define LTE_CLK_FRAME_IMM32 4'h3
// remaining-clock value in which the probe read is on the bus
`define LTE_PROBE_ACC_REM 4'h2

// first-halfword field positions; the nine-bit constant high bits sit in the second halfword
`define LTE_F_RA_HI 15
`define LTE_F_RA_LO 11
`define LTE_F_RB_HI 4
`define LTE_F_RB_LO 0
`define LTE_F_BIT_HI 13
`define LTE_F_BIT_LO 11
`define LTE_F_D9_LO_HI 6
`define LTE_F_D9_LO_LO 4
`define LTE_F_D22_HI 5
`define LTE_F_NINE_HI_HI 5
`define LTE_F_NINE_HI_LO 2
// sub-opcode bits 20:19 sit at bits 4:3 of the second halfword
`define LTE_F_FF_HI 4
`define LTE_F_FF_LO 3

// element pointer source codes
`define LTE_EP_SP 2'h0
`define LTE_EP_SEXT16 2'h1
`define LTE_EP_SHL16 2'h2
`define LTE_EP_IMM32 2'h3

// reset values
`define LTE_RST_REM 4'h0
`define LTE_RST_WORD 32'h0000_0000

`endif

// [testbench.sv]
// testbench: self-checking run of the execution block
// assumes: lte_pkg and lte_mem_model compiled first
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic issue_valid = 1'b0;
    logic stat_ext_write = 1'b0;
    logic [3:0] waits = 4'h0;
    lte_pkg::lte_issue_t iss = '0;
    logic issue_ready, mem_req, mem_ready, done, illegal, wr_en, ep_we;
    logic [31:0] mem_addr, wr_data, ep_data, maddr;
    logic [7:0] mem_rdata;
    logic rdy1;
    logic [4:0] wr_idx;
    lte_pkg::lte_flags_t flags;
    lte_pkg::lte_fields_t fq;
    int errors = 0;
    int n_checks = 0;
    int ncyc;
    localparam logic [15:0] FH0 = 16'ha5d3;
    localparam logic [15:0] FH1 = 16'h3c6b;
    logic [31:0] epx [4] = '{32'h3ff0, 32'hffff_8123, 32'h8123_0000, 32'h4567_8123};
    logic [11:0] lst [3] = '{12'h000, 12'h800, 12'h00c};
    int lcyc [3] = '{1, 1, 2};
    always #50 clk = ~clk;
    lte_exec dut_u (.clk(clk), .rst(rst), .issue_valid(issue_valid), .issue(iss),
        .issue_ready(issue_ready), .stat_ext_write(stat_ext_write), .mem_req(mem_req),
        .mem_addr(mem_addr), .mem_ready(mem_ready), .mem_rdata(mem_rdata), .done(done),
        .illegal(illegal), .wr_en(wr_en), .wr_idx(wr_idx), .wr_data(wr_data),
        .flags(flags), .ep_we(ep_we), .ep_data(ep_data), .fields_q(fq));
    lte_mem_model mem_u (.clk(clk), .mem_req(mem_req), .mem_addr(mem_addr),
        .mem_ready(mem_ready), .mem_rdata(mem_rdata), .waits(waits));
    task automatic stop_test;
        if (errors == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic set(input lte_pkg::lte_class_t c, input logic [15:0] h0, h1,
                       input logic [31:0] a, b);
        iss = '0;
        iss.cls = c;
        iss.hw0 = h0;
        iss.hw1 = h1;
        iss.ra_val = a;
        iss.rb_val = b;
    endtask
    // take edge is cycle 1; ncyc ends at the cycle holding done
    task automatic go;
        @(negedge clk);
        issue_valid = 1'b1;
        @(negedge clk);
        issue_valid = 1'b0;
        ncyc = 1;
        rdy1 = issue_ready;
        maddr = '0;
        while (done !== 1'b1 && illegal !== 1'b1 && ncyc < 40) begin
            if (mem_req === 1'b1 && mem_ready === 1'b1) maddr = mem_addr;
            @(negedge clk);
            ncyc++;
        end
    endtask
    task automatic alu(input lte_pkg::lte_class_t c, input logic [31:0] a, b,
                       input logic [15:0] h1, input logic we, input logic [31:0] r);
        set(c, 16'h5825, h1, a, b);
        go();
        check(ncyc, 1);
        // a finishing and-test loads zero into wr_idx and wr_data, whatever ran before
        check({wr_en, wr_idx}, {we, we ? 5'd11 : 5'h00});
        check(wr_data, we ? r : 32'h0);
        check({26'h0, flags}, {26'h0, 3'b111, 1'b0, r[31], r == 0});
    endtask
    task automatic zx(input lte_pkg::lte_class_t c, input logic [15:0] h0, input logic [31:0] r);
        set(c, h0, 16'h0, 32'h0, 32'h89ab_cdef);
        go();
        check(ncyc, 1);
        check({wr_en, wr_idx, flags.ov_we, flags.s_we, flags.z_we}, {6'h25, 3'b000});
        check(wr_data, r);
    endtask
    task automatic probe(input lte_pkg::lte_class_t c, input logic [15:0] h0, h1,
                         input logic [31:0] a, b, adr, input logic [3:0] w, input logic [2:0] bn);
        logic [7:0] mb;
        mb = adr[7:0] ^ 8'ha5;
        waits = w;
        set(c, h0, h1, a, b);
        go();
        waits = 4'h0;
        check(ncyc, 32'd3 + w);
        check(maddr, adr);
        check(rdy1, 1'b0);
        check({flags.ov_we, flags.s_we, flags.z_we, flags.z, wr_en}, {3'b001, ~mb[bn], 1'b0});
    endtask
    task automatic acc(input lte_pkg::lte_class_t c, input logic cd, input logic [3:0] w,
                       input int exp);
        set(c, 16'h5825, 16'h0, 32'h0, 32'h0);
        iss.cond_dep = cd;
        waits = w;
        go();
        waits = 4'h0;
        check(ncyc, exp);
    endtask
    initial begin
        repeat (8) @(negedge clk);
        rst = 1'b0;
        alu(lte_pkg::lte_cls_and_test_no_write, 32'h0f, 32'hf0, 16'h0, 1'b0, 32'h0);
        alu(lte_pkg::lte_cls_exclusive_or_immediate, 32'h0, 32'hffff_1234, 16'h1234, 1'b1,
            32'hffff_0000);
        zx(lte_pkg::lte_cls_zero_extend_byte, 16'h0085, 32'h0000_00ef);
        zx(lte_pkg::lte_cls_zero_extend_halfword, 16'h00c5, 32'h0000_cdef);
        probe(lte_pkg::lte_cls_probe_disp, 16'hee23, 16'hfff3, 32'h0, 32'h1000, 32'h0ff3,
              4'h2, 3'd5);
        probe(lte_pkg::lte_cls_probe_reg, 16'h3fe3, 16'h00e6, 32'h7, 32'h2041, 32'h2041,
              4'h0, 3'd7);
        alu(lte_pkg::lte_cls_xor_register, 32'h8000_00f0, 32'h0f, 16'h0, 1'b1, 32'h8000_00ff);
        acc(lte_pkg::lte_cls_marked_access, 1'b1, 4'h0, 3);
        acc(lte_pkg::lte_cls_marked_access, 1'b1, 4'h0, 2);
        acc(lte_pkg::lte_cls_marked_access, 1'b0, 4'h1, 3);
        acc(lte_pkg::lte_cls_short_load, 1'b0, 4'h1, 2);
        @(negedge clk);
        stat_ext_write = 1'b1;
        @(negedge clk);
        stat_ext_write = 1'b0;
        acc(lte_pkg::lte_cls_marked_access, 1'b1, 4'h0, 3);
        set(lte_pkg::lte_cls_zero_extend_byte, 16'h0080, 16'h0, 32'h0, 32'h1234);
        iss.chk_rb = 1'b1;
        go();
        check({illegal, done, wr_en, fq.reg_field_bad}, 4'b1001);
        set(lte_pkg::lte_cls_none, FH0, FH1, 32'h0, 32'h0);
        go();
        check(fq.disp9, {FH0[15:11], FH0[6:4], 1'b0});
        check(fq.long_branch_offset, {FH0[5:0], FH1[15:1], 1'b0});
        check(fq.nine_bit_constant, {FH1[5:2], FH0[4:0]});
        check({fq.system_register_index, fq.sysreg_src}, {FH0[15:11], FH0[4:0]});
        for (int ff = 0; ff < 4; ff++) begin
            set(lte_pkg::lte_cls_frame_prep, 16'h0785, {11'h0, ff[1:0], 3'h0}, 32'h0, 32'h0);
            iss.register_select_list = 12'h0a1;
            iss.hw2 = 16'h8123;
            iss.hw3 = 16'h4567;
            iss.stack_pointer = 32'h0000_3ff0;
            go();
            check(ncyc, (ff == 0) ? 4 : (ff == 3) ? 6 : 5);
            check({ep_we, fq.ep_src}, {1'b1, ff[1:0]});
            check(ep_data, epx[ff]);
        end
        foreach (lst[i]) begin
            set(lte_pkg::lte_cls_list_load, 16'h5825, 16'h0, 32'h0, 32'h0);
            iss.register_select_list = lst[i];
            go();
            check(ncyc, lcyc[i]);
        end
        stop_test();
    end
    initial begin
        #(100 * 2000);
        errors++;
        stop_test();
    end
endmodule
`default_nettype wire
